// >>> common/asrb_defines.vh
// asrb_defines.vh: constants for the sampling record builder.
// assumes inclusion by bare name from the design file.
`ifndef ASRB_DEFINES_VH
`define ASRB_DEFINES_VH

// counter population and trigger mask layout
`define ASRB_GP_NUM        8
`define ASRB_FIX_NUM       4
`define ASRB_FIX_MASK_POS  32
// group-select configuration fields
`define ASRB_CFG_MEM_BIT   0
`define ASRB_CFG_GPR_BIT   1
`define ASRB_CFG_VEC_BIT   2
`define ASRB_CFG_BR_BIT    3
`define ASRB_CFG_CNT_BIT   4
`define ASRB_CFG_BRD_LSB   24
`define ASRB_CFG_BRD_MSB   31
// format word fields
`define ASRB_FMT_CFG_MSB   47
`define ASRB_FMT_SIZE_LSB  48
// group word counts, 64-bit words
`define ASRB_BASIC_WORDS   10'h004
`define ASRB_MEM_WORDS     10'h004
`define ASRB_GPR_WORDS     10'h012
`define ASRB_VEC_WORDS     10'h020
`define ASRB_BR_WORDS_PER  10'h003
`define ASRB_CNT_WORDS     10'h00C
// general-register entries: legacy 2..9, extended 10..17
`define ASRB_GPR_LEG_FIRST 10'h002
`define ASRB_GPR_EXT_FIRST 10'h00A
// group codes
`define ASRB_G_BASIC       3'h0
`define ASRB_G_MEM         3'h1
`define ASRB_G_GPR         3'h2
`define ASRB_G_VEC         3'h3
`define ASRB_G_BR          3'h4
`define ASRB_G_CNT         3'h5
`define ASRB_G_DONE        3'h6

`endif

// >>> logic/asrb_record_builder.v
// asrb_record_builder.v: builds variable-length sampling records as a 64-bit word stream.
// assumes the record buffer takes words with valid/ready; register, vector, branch and
// counter group words come from core logic on the same clock, addressed by o_ext_group/index.
`timescale 1ns/1ps
`default_nettype none
`include "asrb_defines.vh"

module asrb_record_builder (
	// clock and reset
	input  wire        i_clk,
	input  wire        i_sys_rst,
	// counter configuration and overflow
	input  wire [7:0]  i_gp_overflow,
	input  wire [3:0]  i_fixed_overflow,
	input  wire [7:0]  i_gp_sampling_enable,
	input  wire [3:0]  i_fixed_sampling_enable,
	input  wire [7:0]  i_gp_event_select_rich,
	input  wire [3:0]  i_fixed_rich_record_enable,
	input  wire [47:0] i_group_select_config,
	// instruction and memory state
	input  wire [63:0] i_eventing_pointer,
	input  wire [63:0] i_timestamp_counter,
	input  wire [63:0] i_mem_address,
	input  wire        i_memory_retire_event,
	input  wire        i_store_sample,
	input  wire [63:0] i_mem_data_source,
	input  wire [63:0] i_mem_store_status,
	input  wire [63:0] i_mem_load_latency,
	input  wire [31:0] i_region_cycles,
	input  wire [31:0] i_region_abort_info,
	input  wire        i_long_mode,
	// external group words
	input  wire [63:0] i_ext_data,
	output wire [2:0]  o_ext_group,
	output wire [9:0]  o_ext_index,
	// record stream
	input  wire        i_wr_ready,
	output wire        o_wr_valid,
	output wire [63:0] o_wr_data,
	output wire        o_wr_last,
	output wire        o_busy
);

	localparam ST_IDLE = 1'b0;
	localparam ST_EMIT = 1'b1;

	reg        state_reg,  state_next;
	reg [63:0] pend_reg,   pend_next;
	reg        prich_reg,  prich_next;
	reg [63:0] mask_reg,   mask_next;
	reg [47:0] sel_reg,    sel_next;
	reg [63:0] ip_reg,     ip_next;
	reg [63:0] ts_reg,     ts_next;
	reg [63:0] addr_reg,   addr_next;
	reg [63:0] aux_reg,    aux_next;
	reg [63:0] lat_reg,    lat_next;
	reg [63:0] tx_reg,     tx_next;
	reg [15:0] size_reg,   size_next;
	reg [2:0]  grp_reg,    grp_next;
	reg [9:0]  idx_reg,    idx_next;
	reg        valid_reg,  valid_next;
	reg [63:0] data_reg,   data_next;
	reg        last_reg,   last_next;

	// words in a group under a given selection; zero when unselected
	function [9:0] grp_words;
		input [2:0]  g;
		input [47:0] sel;
		begin
			case (g)
				`ASRB_G_BASIC: grp_words = `ASRB_BASIC_WORDS;
				`ASRB_G_MEM:   grp_words = sel[`ASRB_CFG_MEM_BIT] ? `ASRB_MEM_WORDS : 10'h000;
				`ASRB_G_GPR:   grp_words = sel[`ASRB_CFG_GPR_BIT] ? `ASRB_GPR_WORDS : 10'h000;
				`ASRB_G_VEC:   grp_words = sel[`ASRB_CFG_VEC_BIT] ? `ASRB_VEC_WORDS : 10'h000;
				`ASRB_G_BR:    grp_words = sel[`ASRB_CFG_BR_BIT] ?
					((`ASRB_BR_WORDS_PER * {2'h0, sel[`ASRB_CFG_BRD_MSB:`ASRB_CFG_BRD_LSB]}) & 10'h3FF)
					: 10'h000;
				`ASRB_G_CNT:   grp_words = sel[`ASRB_CFG_CNT_BIT] ? `ASRB_CNT_WORDS : 10'h000;
				default:       grp_words = 10'h000;
			endcase
		end
	endfunction

	// next group after g holding at least one word; skipped groups take no space
	function [2:0] next_grp;
		input [2:0]  g;
		input [47:0] sel;
		reg   [2:0]  n;
		integer      k;
		begin
			n = `ASRB_G_DONE;
			for (k = 5; k >= 1; k = k - 1) begin
				if (k > g && grp_words(k[2:0], sel) != 10'h000) begin
					n = k[2:0];
				end
			end
			next_grp = n;
		end
	endfunction

	wire [63:0] trig_now;
	wire        rich_now;
	wire        rich_pend;
	wire [47:0] cfg_sel;
	wire [9:0]  total_words;

	assign trig_now = {{(32 - `ASRB_FIX_NUM){1'b0}}, i_fixed_overflow & i_fixed_sampling_enable,
		{(32 - `ASRB_GP_NUM){1'b0}}, i_gp_overflow & i_gp_sampling_enable};
	assign rich_now = |(i_gp_overflow & i_gp_sampling_enable & i_gp_event_select_rich)
		| |(i_fixed_overflow & i_fixed_sampling_enable & i_fixed_rich_record_enable);
	// basic-only records see an empty selection
	// queued rich triggers count too, not only this cycle's
	assign rich_pend = prich_reg | rich_now;
	assign cfg_sel = rich_pend ? i_group_select_config : 48'h0;
	assign total_words = grp_words(`ASRB_G_BASIC, cfg_sel) + grp_words(`ASRB_G_MEM, cfg_sel)
		+ grp_words(`ASRB_G_GPR, cfg_sel) + grp_words(`ASRB_G_VEC, cfg_sel)
		+ grp_words(`ASRB_G_BR, cfg_sel) + grp_words(`ASRB_G_CNT, cfg_sel);

	reg [63:0] word;
	reg        out_free;
	reg        at_end;

	always @* begin
		state_next = state_reg;
		pend_next  = pend_reg | trig_now;
		prich_next = prich_reg | rich_now;
		mask_next  = mask_reg;
		sel_next   = sel_reg;
		ip_next    = ip_reg;
		ts_next    = ts_reg;
		addr_next  = addr_reg;
		aux_next   = aux_reg;
		lat_next   = lat_reg;
		tx_next    = tx_reg;
		size_next  = size_reg;
		grp_next   = grp_reg;
		idx_next   = idx_reg;
		valid_next = valid_reg;
		data_next  = data_reg;
		last_next  = last_reg;
		out_free   = !valid_reg || i_wr_ready;
		at_end     = (idx_reg + 10'h001) == grp_words(grp_reg, sel_reg);
		word       = 64'h0;
		if (valid_reg && i_wr_ready) begin
			valid_next = 1'b0;
			last_next  = 1'b0;
		end
		case (state_reg)
			ST_IDLE: begin
				// overflows that land while a record is built wait here, not lost
				if (pend_next != 64'h0 && out_free) begin
					state_next = ST_EMIT;
					mask_next  = pend_next;
					sel_next   = cfg_sel;
					size_next  = {3'h0, total_words, 3'h0};
					ip_next    = i_eventing_pointer;
					ts_next    = i_timestamp_counter;
					addr_next  = i_mem_address;
					aux_next   = i_memory_retire_event ? i_mem_data_source :
						(i_store_sample ? i_mem_store_status : 64'h0);
					lat_next   = i_memory_retire_event ? i_mem_load_latency : 64'h0;
					tx_next    = {i_region_abort_info, i_region_cycles};
					grp_next   = `ASRB_G_BASIC;
					idx_next   = 10'h000;
					// capture-cycle overflows already sit in this mask; keeping them would repeat the record
					pend_next  = 64'h0;
					prich_next = 1'b0;
				end
			end
			ST_EMIT: begin
				if (out_free) begin
					case (grp_reg)
						`ASRB_G_BASIC: begin
							case (idx_reg[1:0])
								2'h0:    word = {size_reg, sel_reg};
								2'h1:    word = ip_reg;
								2'h2:    word = mask_reg;
								default: word = ts_reg;
							endcase
						end
						`ASRB_G_MEM: begin
							case (idx_reg[1:0])
								2'h0:    word = addr_reg;
								2'h1:    word = aux_reg;
								2'h2:    word = lat_reg;
								default: word = tx_reg;
							endcase
						end
						`ASRB_G_GPR: begin
							// flags and pointer entries pass whole in any mode
							if (i_long_mode || idx_reg < `ASRB_GPR_LEG_FIRST) begin
								word = i_ext_data;
							end else if (idx_reg < `ASRB_GPR_EXT_FIRST) begin
								word = {32'h0, i_ext_data[31:0]};
							end else begin
								word = 64'h0;
							end
						end
						default: word = i_ext_data;
					endcase
					valid_next = 1'b1;
					data_next  = word;
					last_next  = 1'b0;
					if (at_end) begin
						grp_next = next_grp(grp_reg, sel_reg);
						idx_next = 10'h000;
						if (next_grp(grp_reg, sel_reg) == `ASRB_G_DONE) begin
							last_next  = 1'b1;
							state_next = ST_IDLE;
						end
					end else begin
						idx_next = idx_reg + 10'h001;
					end
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			state_reg <= ST_IDLE;
			pend_reg  <= 64'h0;
			prich_reg <= 1'b0;
			mask_reg  <= 64'h0;
			sel_reg   <= 48'h0;
			ip_reg    <= 64'h0;
			ts_reg    <= 64'h0;
			addr_reg  <= 64'h0;
			aux_reg   <= 64'h0;
			lat_reg   <= 64'h0;
			tx_reg    <= 64'h0;
			size_reg  <= 16'h0;
			grp_reg   <= `ASRB_G_BASIC;
			idx_reg   <= 10'h000;
			valid_reg <= 1'b0;
			data_reg  <= 64'h0;
			last_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			pend_reg  <= pend_next;
			prich_reg <= prich_next;
			mask_reg  <= mask_next;
			sel_reg   <= sel_next;
			ip_reg    <= ip_next;
			ts_reg    <= ts_next;
			addr_reg  <= addr_next;
			aux_reg   <= aux_next;
			lat_reg   <= lat_next;
			tx_reg    <= tx_next;
			size_reg  <= size_next;
			grp_reg   <= grp_next;
			idx_reg   <= idx_next;
			valid_reg <= valid_next;
			data_reg  <= data_next;
			last_reg  <= last_next;
		end
	end

	assign o_ext_group = grp_reg;
	assign o_ext_index = idx_reg;
	assign o_wr_valid  = valid_reg;
	assign o_wr_data   = data_reg;
	assign o_wr_last   = last_reg;
	assign o_busy      = state_reg;

endmodule

`default_nettype wire

// >>> sim/asrb_monitor.sv
// asrb_monitor.sv: port assertions for the record builder.
// assumes a bind onto asrb_record_builder, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module asrb_monitor (
	input wire logic        i_clk,
	input wire logic        i_sys_rst,
	input wire logic [7:0]  i_gp_overflow,
	input wire logic [7:0]  i_gp_sampling_enable,
	input wire logic [47:0] i_group_select_config,
	input wire logic        i_wr_ready,
	input wire logic        o_wr_valid,
	input wire logic [63:0] o_wr_data,
	input wire logic        o_wr_last,
	input wire logic        o_busy
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	logic [9:0]  wcnt;
	logic [15:0] size_reg;
	wire         take = o_wr_valid & i_wr_ready;
	// word index within the record, size latched from the format word
	always @(posedge i_clk) begin
		if (i_sys_rst || (take && o_wr_last))
			wcnt <= 10'h000;
		else if (take)
			wcnt <= wcnt + 10'h001;
		if (take && wcnt == 10'h000)
			size_reg <= o_wr_data[63:48];
	end
	valid_hold_a: assert property (o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable(o_wr_data) && $stable(o_wr_last))
		else $error("stalled word changed");
	trig_start_a: assert property (!o_busy && !o_wr_valid && (i_gp_overflow & i_gp_sampling_enable) != 8'h00 |=> o_busy ##1 o_wr_valid)
		else $error("trigger did not start a record");
	format_cfg_a: assert property (o_wr_valid && wcnt == 10'h000 |-> o_wr_data[47:0] == 48'h0 || o_wr_data[47:0] == i_group_select_config)
		else $error("format low field wrong");
	size_match_a: assert property (take && o_wr_last |-> ({3'b000, wcnt, 3'b000} + 16'h0008) == size_reg)
		else $error("record size disagrees with length");
	mask_bits_a: assert property (take && wcnt == 10'h002 |-> o_wr_data != 64'h0 && (o_wr_data & 64'hFFFFFFF0FFFFFF00) == 64'h0)
		else $error("trigger mask bad");
	basic_len_a: assert property (take && o_wr_last |-> wcnt >= 10'h003)
		else $error("record shorter than basic group");
	last_free_a: assert property (o_wr_valid && o_wr_last |-> !o_busy)
		else $error("busy held after last word");
	first_word_a: assert property ($rose(o_busy) |=> o_wr_valid && wcnt == 10'h000)
		else $error("record start not at format word");
endmodule
`default_nettype wire

// >>> sim/asrb_buffer_model.sv
// asrb_buffer_model.sv: record buffer taking the builder's word stream.
// assumes one clock; i_slow stalls every other cycle.
`timescale 1ns/1ps
`default_nettype none
module asrb_buffer_model (
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_slow,
	input  wire logic        i_wr_valid,
	input  wire logic [63:0] i_wr_data,
	input  wire logic        i_wr_last,
	output var  logic        o_wr_ready,
	output var  int          o_nw
);
	logic [63:0] mem [0:255];
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_nw <= 0;
			o_wr_ready <= 1'b0;
		end else begin
			o_wr_ready <= i_slow ? ~o_wr_ready : 1'b1;
			if (i_wr_valid && o_wr_ready) begin
				mem[o_nw[7:0]] <= i_wr_data;
				o_nw <= o_nw + 1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// tb_top.sv: record builder tests against the buffer model.
// assumes the builder and buffer model compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        slow = 1'b0;
	logic        retire = 1'b0;
	logic        store = 1'b0;
	logic        lmode = 1'b1;
	logic [7:0]  gp_ovf = 8'h00;
	logic [3:0]  fx_ovf = 4'h0;
	logic [47:0] cfg = 48'h000003;
	logic [63:0] ptr = 64'h00007FFF12345678;
	logic [63:0] ts = 64'h000000ABCDEF0123;
	logic [63:0] adr = 64'hFFFF800000001000;
	logic [31:0] cyc = 32'h00000123;
	logic [31:0] abt = 32'h00000005;
	logic [2:0]  grp;
	logic [9:0]  idx;
	logic        valid, last, ready, busy;
	logic [63:0] data;
	int          nw, base;
	int          err_count = 0;
	int          n_checks = 0;
	asrb_record_builder i_asrb_record_builder (.i_clk(clk), .i_sys_rst(rst),
		.i_gp_overflow(gp_ovf), .i_fixed_overflow(fx_ovf), .i_gp_sampling_enable(8'hEF),
		.i_fixed_sampling_enable(4'hF), .i_gp_event_select_rich(8'h08), .i_fixed_rich_record_enable(4'h2),
		.i_group_select_config(cfg), .i_eventing_pointer(ptr), .i_timestamp_counter(ts),
		.i_mem_address(adr), .i_memory_retire_event(retire), .i_store_sample(store),
		.i_mem_data_source(ts ^ adr), .i_mem_store_status(~adr), .i_mem_load_latency(ptr ^ ts),
		.i_region_cycles(cyc), .i_region_abort_info(abt), .i_long_mode(lmode),
		.i_ext_data({32'h5A5A5A5A, 19'h0, grp, idx}), .o_ext_group(grp), .o_ext_index(idx),
		.i_wr_ready(ready), .o_wr_valid(valid), .o_wr_data(data), .o_wr_last(last), .o_busy(busy));
	asrb_buffer_model i_asrb_buffer_model (.i_clk(clk), .i_sys_rst(rst), .i_slow(slow),
		.i_wr_valid(valid), .i_wr_data(data), .i_wr_last(last), .o_wr_ready(ready), .o_nw(nw));
	task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [63:0] w(input int i);
		return i_asrb_buffer_model.mem[base + i];
	endfunction
	// one overflow pulse, then wait for the record to drain
	task automatic fire(input logic [7:0] g, input logic [3:0] f);
		int k;
		base = nw;
		@(negedge clk);
		gp_ovf = g;
		fx_ovf = f;
		@(negedge clk);
		gp_ovf = 8'h00;
		fx_ovf = 4'h0;
		// busy drops as the last word appears; wait until it is taken too
		for (k = 0; k < 300 && (busy !== 1'b0 || valid !== 1'b0); k++)
			@(negedge clk);
		chk("drained", {62'h0, busy, valid}, 64'h0);
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		forever #2.5 clk = ~clk;
	end
	// whole run is somewhat over a hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		stop_test();
	end
	initial begin
		repeat (2) @(negedge clk);
		rst = 1'b0;
		// groups selected but trigger not rich: basic only
		fire(8'h01, 4'h0);
		chk("count", nw - base, 64'h4);
		chk("format", w(0), {16'h0020, 48'h0});
		chk("pointer", w(1), ptr);
		chk("mask", w(2), 64'h1);
		chk("stamp", w(3), ts);
		$display("test basic done");
		cfg = 48'h000001;
		retire = 1'b1;
		fire(8'h08, 4'h0);
		chk("count", nw - base, 64'h8);
		chk("format", w(0), {16'h0040, 48'h1});
		chk("address", w(4), adr);
		chk("source", w(5), ts ^ adr);
		chk("latency", w(6), ptr ^ ts);
		chk("cycles", w(7) & 64'hFFFFFFFF, {32'h0, cyc});
		chk("abort", w(7) >> 32, {32'h0, abt});
		$display("test memory done");
		cfg = 48'h000003;
		retire = 1'b0;
		store = 1'b1;
		lmode = 1'b0;
		slow = 1'b1;
		fire(8'h00, 4'h2);
		chk("count", nw - base, 64'h1A);
		chk("format", w(0), {16'h00D0, 48'h3});
		chk("mask", w(2), 64'h0000000200000000);
		chk("status", w(5), ~adr);
		chk("latency", w(6), 64'h0);
		chk("legacy", w(10), {51'h0, 3'h2, 10'h002});
		chk("extended", w(18), 64'h0);
		$display("test registers done");
		slow = 1'b0;
		lmode = 1'b1;
		store = 1'b0;
		// gp4 has sampling off and must not show in the mask
		fire(8'h14, 4'h1);
		chk("count", nw - base, 64'h4);
		chk("format", w(0), {16'h0020, 48'h0});
		chk("mask", w(2), 64'h0000000100000004);
		$display("test multi done");
		// two overflows queued behind a running basic record merge into one rich record
		cfg = 48'h000001;
		base = nw;
		@(negedge clk);
		gp_ovf = 8'h01;
		@(negedge clk);
		@(negedge clk);
		gp_ovf = 8'h08;
		@(negedge clk);
		gp_ovf = 8'h00;
		repeat (24) @(negedge clk);
		chk("count", nw - base, 64'hC);
		chk("first mask", w(2), 64'h1);
		chk("merged format", w(4), {16'h0040, 48'h1});
		chk("merged mask", w(6), 64'h9);
		$display("test merge done");
		stop_test();
	end
endmodule
bind asrb_record_builder asrb_monitor i_asrb_monitor (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
	.i_gp_overflow(i_gp_overflow), .i_gp_sampling_enable(i_gp_sampling_enable),
	.i_group_select_config(i_group_select_config), .i_wr_ready(i_wr_ready), .o_wr_valid(o_wr_valid),
	.o_wr_data(o_wr_data), .o_wr_last(o_wr_last), .o_busy(o_busy));
`default_nettype wire
